// File: design/dac_link_slave.sv
`timescale 1ns/10ps
`include "dac_link_regs.svh"
// Contract
// - idle device leaves both lines released
// - master alone makes clock, addresses, conditions
// - device is slave, never drives clock
// - start is data falling while clock high
// - transmitter keeps data stable while clock high
// - ack ninth clock only on address match
// - stop is data rising while clock high
// - after stop wait for start and address
// - only 7-bit addresses, no general call
// - standard, fast and high-speed rates
// - master code switches high speed, no ack
// - repeated start then normal protocol faster
// - stop ends high-speed operation
// - master prefers repeated start in high speed
// - channel code is unsigned 16-bit binary
// - address 10011 plus two strapped select bits
// - broadcast address accepted for writes only
// - msb byte then lsb byte, each acked
// - apply update at fall ending lsb ack
module dac_link_slave
  import dac_link_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int CODE_W   = 16
) (
  input  wire logic                             clk_i,       // link sampling
  input  wire logic                             reset_i,     // async, high
  input  wire logic                             user_clk_i,  // output domain
  input  wire logic                             select_pin_upper_i, // strap
  input  wire logic                             select_pin_lower_i, // strap
  output logic [CHANNELS-1:0][CODE_W-1:0]       code_o,      // channel codes
  output logic                                  update_o,    // code written
  output logic                                  high_speed_operation_o, // hs
  two_wire_if.device                            bus          // serial lines
);

  // ==========================================
  // elaboration checks
  if (CHANNELS != 4 || CODE_W != 16) begin : g_chk
    $error("dac_link_slave serves four 16-bit channels only");
  end

  function automatic logic addr_hit(input logic [7:0] b,
                                    input logic [1:0] sel);
    addr_hit = (b[7:1] == {`DL_ADDR_FIXED, sel}) ||
               (b[7:1] == `DL_BCAST_ADDR && b[0] != `DL_RW_READ);
  endfunction

  // ==========================================
  // line synchronisers
  logic [2:0]   scl_s_q;
  logic [2:0]   sda_s_q;
  logic         scl_q;
  logic         sda_q;
  logic         scl_p_q;
  logic         sda_p_q;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_ev;
  logic         stop_ev;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_q   <= 1'h1;
      sda_q   <= 1'h1;
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], bus.scl};
      sda_s_q <= {sda_s_q[1:0], bus.sda};
      if (scl_s_q[2] == scl_s_q[1]) begin
        scl_q <= scl_s_q[2];
      end
      if (sda_s_q[2] == sda_s_q[1]) begin
        sda_q <= sda_s_q[2];
      end
      scl_p_q <= scl_q;
      sda_p_q <= sda_q;
    end
  end

  assign scl_rise = scl_q & ~scl_p_q;
  assign scl_fall = ~scl_q & scl_p_q;
  assign start_ev = scl_q & scl_p_q & sda_p_q & ~sda_q;
  assign stop_ev  = scl_q & scl_p_q & ~sda_p_q & sda_q;

  // ==========================================
  // select straps, caught a few clocks after reset release
  logic [1:0]   sel_s0_q;
  logic [1:0]   sel_s1_q;
  logic [1:0]   sel_s2_q;
  logic [1:0]   sel_q;
  logic [2:0]   strap_cnt_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sel_s0_q    <= 2'h0;
      sel_s1_q    <= 2'h0;
      sel_s2_q    <= 2'h0;
      sel_q       <= 2'h0;
      strap_cnt_q <= 3'h0;
    end else begin
      sel_s0_q <= {select_pin_upper_i, select_pin_lower_i};
      sel_s1_q <= sel_s0_q;
      sel_s2_q <= sel_s1_q;
      // frozen after power-up: later pin changes are ignored
      // stages still hold reset zeros early on: wait for agreement
      if (strap_cnt_q != `DL_STRAP_SETTLE) begin
        strap_cnt_q <= strap_cnt_q + 3'h1;
        if (sel_s2_q == sel_s1_q) begin
          sel_q <= sel_s2_q;
        end
      end
    end
  end

  // ==========================================
  // protocol engine
  slave_state_e state_q;
  logic [3:0]   bit_cnt_q;
  logic [1:0]   byte_idx_q;
  logic [7:0]   sh_q;
  logic [7:0]   ctrl_q;
  logic [7:0]   msb_q;
  logic [7:0]   tx_q;
  logic         tx_lo_q;
  logic         rw_q;
  logic         sda_oe_n_q;
  logic [15:0]  word_q;
  logic         apply;
  logic         mcode_hit;

  assign mcode_hit = (state_q == S_RECV) && scl_fall &&
                     bit_cnt_q == `DL_ACK_BIT &&
                     byte_idx_q == `DL_BYTE_ADDR &&
                     sh_q[7:3] == `DL_MCODE_TOP;
  assign apply = (state_q == S_ACK) && scl_fall && !rw_q &&
                 byte_idx_q == `DL_BYTE_LSB;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q    <= S_IDLE;
      bit_cnt_q  <= 4'h0;
      byte_idx_q <= `DL_BYTE_ADDR;
      sh_q       <= 8'h00;
      ctrl_q     <= 8'h00;
      msb_q      <= 8'h00;
      tx_q       <= 8'h00;
      tx_lo_q    <= 1'h0;
      rw_q       <= 1'h0;
      sda_oe_n_q <= 1'h1;
    end else if (start_ev) begin
      // also a repeated start in mid-byte: address reception restarts
      state_q    <= S_RECV;
      bit_cnt_q  <= 4'h0;
      byte_idx_q <= `DL_BYTE_ADDR;
      sda_oe_n_q <= 1'h1;
    end else if (stop_ev) begin
      state_q    <= S_IDLE;
      sda_oe_n_q <= 1'h1;
    end else begin
      case (state_q)
        S_RECV: begin
          if (scl_rise && bit_cnt_q != `DL_ACK_BIT) begin
            sh_q      <= {sh_q[6:0], sda_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == `DL_ACK_BIT) begin
            bit_cnt_q <= 4'h0;
            if (byte_idx_q == `DL_BYTE_ADDR) begin
              if (!mcode_hit && addr_hit(sh_q, sel_q)) begin
                rw_q       <= sh_q[0];
                state_q    <= S_ACK;
                sda_oe_n_q <= 1'h0;
              end else begin
                state_q <= S_IGNORE;
              end
            end else begin
              state_q    <= S_ACK;
              sda_oe_n_q <= 1'h0;
              if (byte_idx_q == `DL_BYTE_CTRL) begin
                ctrl_q <= sh_q;
              end
              if (byte_idx_q == `DL_BYTE_MSB) begin
                msb_q <= sh_q;
              end
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              state_q    <= S_SEND;
              tx_q       <= word_q[15:8];
              tx_lo_q    <= 1'h1;
              sda_oe_n_q <= word_q[15];
            end else begin
              state_q    <= S_RECV;
              sda_oe_n_q <= 1'h1;
              // back-to-back updates need only msb and lsb again
              byte_idx_q <= (byte_idx_q == `DL_BYTE_LSB) ? `DL_BYTE_MSB
                                                         : byte_idx_q + 2'h1;
            end
          end
        end
        S_SEND: begin
          if (scl_fall) begin
            if (bit_cnt_q == `DL_LAST_BIT) begin
              bit_cnt_q  <= 4'h0;
              state_q    <= S_WACK;
              sda_oe_n_q <= 1'h1;
            end else begin
              bit_cnt_q  <= bit_cnt_q + 4'h1;
              tx_q       <= {tx_q[6:0], 1'h0};
              sda_oe_n_q <= tx_q[6];
            end
          end
        end
        S_WACK: begin
          if (scl_rise && sda_q) begin
            state_q <= S_IGNORE;
          end else if (scl_fall) begin
            state_q    <= S_SEND;
            tx_q       <= tx_lo_q ? word_q[7:0] : word_q[15:8];
            sda_oe_n_q <= tx_lo_q ? word_q[7] : word_q[15];
            tx_lo_q    <= ~tx_lo_q;
          end
        end
        default: begin
          sda_oe_n_q <= 1'h1;
        end
      endcase
    end
  end

  // ==========================================
  // high-speed flag
  logic         hs_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      hs_q <= 1'h0;
    end else if (stop_ev) begin
      hs_q <= 1'h0;
    end else if (mcode_hit) begin
      hs_q <= 1'h1;
    end
  end

  // ==========================================
  // update capture and toggle handoff
  logic         upd_tgl_q;
  logic [1:0]   upd_chan_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      upd_tgl_q  <= 1'h0;
      upd_chan_q <= 2'h0;
      word_q     <= 16'h0000;
    end else if (apply) begin
      // held until the next update, far longer than the crossing takes
      word_q     <= {msb_q, sh_q};
      upd_chan_q <= ctrl_q[`DL_CTRL_SEL_HI:`DL_CTRL_SEL_LO];
      upd_tgl_q  <= ~upd_tgl_q;
    end
  end

  logic [2:0]   tgl_s_q;
  logic         seen_q;
  logic         upd_q;
  logic [CHANNELS-1:0][CODE_W-1:0] code_q;

  always_ff @(posedge user_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tgl_s_q <= 3'h0;
      seen_q  <= 1'h0;
      upd_q   <= 1'h0;
      code_q  <= '0;
    end else begin
      tgl_s_q <= {tgl_s_q[1:0], upd_tgl_q};
      upd_q   <= 1'h0;
      if (tgl_s_q[2] == tgl_s_q[1] && tgl_s_q[2] != seen_q) begin
        seen_q             <= tgl_s_q[2];
        upd_q              <= 1'h1;
        code_q[upd_chan_q] <= word_q;
      end
    end
  end

  assign code_o                 = code_q;
  assign update_o               = upd_q;
  assign high_speed_operation_o = hs_q;
  assign bus.d_sda_oe_n         = sda_oe_n_q;
  assign bus.d_sda_out          = 1'h0;
  assign bus.d_scl_oe_n         = 1'h1;
  assign bus.d_scl_out          = 1'h0;

endmodule // dac_link_slave

// File: design/dac_link_regs.svh
`ifndef DAC_LINK_REGS_SVH
`define DAC_LINK_REGS_SVH

// ==========================================
// timing
`define DL_CLK_KHZ       40000
`define DL_FS_KBPS       400
`define DL_HS_KBPS       3400
// quarter of a bit period, least time so rounded up
`define DL_FS_QUARTER    ((`DL_CLK_KHZ + 4*`DL_FS_KBPS - 1) / (4*`DL_FS_KBPS))
`define DL_HS_QUARTER    ((`DL_CLK_KHZ + 4*`DL_HS_KBPS - 1) / (4*`DL_HS_KBPS))
// straps pass three stages before they may be captured
`define DL_STRAP_SETTLE  3'h5

// ==========================================
// address and byte layout
`define DL_ADDR_FIXED    5'h13
`define DL_BCAST_ADDR    7'h48
`define DL_MCODE_TOP     5'h01
`define DL_RW_READ       1'h1
`define DL_CTRL_SEL_HI   2
`define DL_CTRL_SEL_LO   1
`define DL_ACK_BIT       4'h8
`define DL_LAST_BIT      4'h7
`define DL_BYTE_ADDR     2'h0
`define DL_BYTE_CTRL     2'h1
`define DL_BYTE_MSB      2'h2
`define DL_BYTE_LSB      2'h3
`define DL_MB_MCODE      3'h0
`define DL_MB_ADDR       3'h1
`define DL_MB_CTRL       3'h2
`define DL_MB_MSB        3'h3
`define DL_MB_LSB        3'h4
`define DL_Q0            2'h0
`define DL_Q1            2'h1
`define DL_Q2            2'h2
`define DL_Q3            2'h3

`endif

// File: design/dac_link_pkg.sv
package dac_link_pkg;

  typedef enum logic [2:0] {
    S_IDLE, S_RECV, S_ACK, S_SEND, S_WACK, S_IGNORE
  } slave_state_e;

  typedef enum logic [1:0] {
    M_IDLE, M_START, M_BIT, M_STOP
  } master_state_e;

endpackage

// File: design/two_wire_if.sv
`timescale 1ns/10ps
// ==========================================
// open-drain bus: a line is low when any enabled driver pulls it low
interface two_wire_if;
  logic m_scl_out;
  logic m_scl_oe_n;
  logic m_sda_out;
  logic m_sda_oe_n;
  logic d_scl_out;
  logic d_scl_oe_n;
  logic d_sda_out;
  logic d_sda_oe_n;
  logic scl;
  logic sda;

  assign scl = (m_scl_oe_n | m_scl_out) & (d_scl_oe_n | d_scl_out);
  assign sda = (m_sda_oe_n | m_sda_out) & (d_sda_oe_n | d_sda_out);

  modport master (output m_scl_out, m_scl_oe_n, m_sda_out, m_sda_oe_n,
                  input scl, sda);
  modport device (output d_scl_out, d_scl_oe_n, d_sda_out, d_sda_oe_n,
                  input scl, sda);
endinterface

// File: design/dac_link_master.sv
`timescale 1ns/10ps
`include "dac_link_regs.svh"
// ==========================================
// bus master: writes one update, optionally in high speed
module dac_link_master
  import dac_link_pkg::*;
#(
  parameter logic [2:0] MCODE_IDX = 3'h1
) (
  input  wire logic        clk_i,    // system clock
  input  wire logic        reset_i,  // async, high
  input  wire logic        start_i,  // begin transfer, pulse
  input  wire logic        hs_i,     // use high speed
  input  wire logic [6:0]  addr_i,   // slave address
  input  wire logic [7:0]  ctrl_i,   // control byte
  input  wire logic [15:0] data_i,   // channel code
  output logic             busy_o,   // transfer running
  output logic             done_o,   // transfer finished, pulse
  output logic             nack_o,   // last transfer refused
  output logic             hs_active_o, // high speed clock in use
  two_wire_if.master       bus       // serial lines
);

  // ==========================================
  // quarter-bit timer
  logic [5:0]    qcnt_q;
  logic          tick;
  logic          hs_q;

  assign tick = (qcnt_q == 6'h00);

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      qcnt_q <= 6'h00;
    end else if (tick) begin
      qcnt_q <= hs_q ? 6'(`DL_HS_QUARTER - 1) : 6'(`DL_FS_QUARTER - 1);
    end else begin
      qcnt_q <= qcnt_q - 6'h01;
    end
  end

  // ==========================================
  // data line sampler
  logic [2:0]    sda_s_q;
  logic          sda_q;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sda_s_q <= 3'h7;
      sda_q   <= 1'h1;
    end else begin
      sda_s_q <= {sda_s_q[1:0], bus.sda};
      if (sda_s_q[2] == sda_s_q[1]) begin
        sda_q <= sda_s_q[2];
      end
    end
  end

  // ==========================================
  // sequencer
  master_state_e state_q;
  logic [1:0]    q_q;
  logic [2:0]    sel_q;
  logic [3:0]    bit_cnt_q;
  logic [7:0]    tx_q;
  logic          scl_oe_n_q;
  logic          sda_oe_n_q;
  logic          busy_q;
  logic          done_q;
  logic          nack_q;
  logic [6:0]    addr_q;
  logic [7:0]    ctrl_q;
  logic [15:0]   data_q;

  function automatic logic [7:0] byte_of(input logic [2:0] s,
                                         input logic [6:0] a,
                                         input logic [7:0] c,
                                         input logic [15:0] d);
    case (s)
      `DL_MB_MCODE: byte_of = {`DL_MCODE_TOP, MCODE_IDX};
      `DL_MB_ADDR:  byte_of = {a, 1'h0};
      `DL_MB_CTRL:  byte_of = c;
      `DL_MB_MSB:   byte_of = d[15:8];
      default:      byte_of = d[7:0];
    endcase
  endfunction

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q    <= M_IDLE;
      q_q        <= `DL_Q0;
      sel_q      <= `DL_MB_ADDR;
      bit_cnt_q  <= 4'h0;
      tx_q       <= 8'h00;
      scl_oe_n_q <= 1'h1;
      sda_oe_n_q <= 1'h1;
      busy_q     <= 1'h0;
      done_q     <= 1'h0;
      nack_q     <= 1'h0;
      hs_q       <= 1'h0;
      addr_q     <= 7'h00;
      ctrl_q     <= 8'h00;
      data_q     <= 16'h0000;
    end else begin
      done_q <= 1'h0;
      if (state_q == M_IDLE) begin
        if (start_i) begin
          state_q <= M_START;
          q_q     <= `DL_Q0;
          busy_q  <= 1'h1;
          nack_q  <= 1'h0;
          addr_q  <= addr_i;
          ctrl_q  <= ctrl_i;
          data_q  <= data_i;
          sel_q   <= hs_i ? `DL_MB_MCODE : `DL_MB_ADDR;
        end
      end else if (tick) begin
        q_q <= q_q + 2'h1;
        case (state_q)
          M_START: begin
            case (q_q)
              `DL_Q0: sda_oe_n_q <= 1'h1;
              `DL_Q1: scl_oe_n_q <= 1'h1;
              `DL_Q2: sda_oe_n_q <= 1'h0;
              default: begin
                scl_oe_n_q <= 1'h0;
                state_q    <= M_BIT;
                bit_cnt_q  <= 4'h0;
                tx_q       <= byte_of(sel_q, addr_q, ctrl_q, data_q);
              end
            endcase
          end
          M_BIT: begin
            case (q_q)
              `DL_Q0: sda_oe_n_q <= (bit_cnt_q == `DL_ACK_BIT) | tx_q[7];
              `DL_Q1: scl_oe_n_q <= 1'h1;
              // sampled data lags the pin by four clocks; ack read at q3
              `DL_Q2: scl_oe_n_q <= 1'h1;
              default: begin
                scl_oe_n_q <= 1'h0;
                if (bit_cnt_q != `DL_ACK_BIT) begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  tx_q      <= {tx_q[6:0], 1'h0};
                end else if (sel_q == `DL_MB_MCODE) begin
                  // nobody acks the master code; restart at high speed
                  hs_q    <= 1'h1;
                  sel_q   <= `DL_MB_ADDR;
                  state_q <= M_START;
                end else if (sda_q || sel_q == `DL_MB_LSB) begin
                  nack_q  <= sda_q;
                  state_q <= M_STOP;
                end else begin
                  sel_q     <= sel_q + 3'h1;
                  bit_cnt_q <= 4'h0;
                  tx_q      <= byte_of(sel_q + 3'h1, addr_q, ctrl_q, data_q);
                end
              end
            endcase
          end
          default: begin
            case (q_q)
              `DL_Q0: sda_oe_n_q <= 1'h0;
              `DL_Q1: scl_oe_n_q <= 1'h1;
              `DL_Q2: sda_oe_n_q <= 1'h1;
              default: begin
                state_q <= M_IDLE;
                busy_q  <= 1'h0;
                done_q  <= 1'h1;
                hs_q    <= 1'h0;
              end
            endcase
          end
        endcase
      end
    end
  end

  assign busy_o         = busy_q;
  assign done_o         = done_q;
  assign nack_o         = nack_q;
  assign hs_active_o    = hs_q;
  assign bus.m_scl_oe_n = scl_oe_n_q;
  assign bus.m_scl_out  = 1'h0;
  assign bus.m_sda_oe_n = sda_oe_n_q;
  assign bus.m_sda_out  = 1'h0;

endmodule // dac_link_master

// File: tb/dac_link_monitor.sv
`timescale 1ns/10ps
// ==========================================
// link checker, watches the shared lines
module dac_link_monitor #(
  parameter logic [1:0] SEL = 2'h2
) (
  input  wire logic clk_i,       // link sampling clock
  input  wire logic reset_i,     // async, high
  input  wire logic scl,         // clock line level
  input  wire logic sda,         // data line level
  input  wire logic d_scl_oe_n,  // device clock pull, low = pulling
  input  wire logic d_sda_oe_n   // device data pull, low = pulling
);
  logic       scl_q, sda_q, busy_q, acked_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] sh_q;
  wire start_w = scl & scl_q & sda_q & ~sda;
  wire stop_w  = scl & scl_q & ~sda_q & sda;
  wire rise_w  = scl & ~scl_q;
  wire fall_w  = ~scl & scl_q;
  wire slot_w  = rise_w & (bit_q == 4'h8);
  wire match_w = (sh_q[7:1] == {5'h13, SEL}) | (sh_q == 8'h90);

  // ==========================================
  // framing helpers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) busy_q <= 1'b0;
    else if (start_w) busy_q <= 1'b1;
    else if (stop_w) busy_q <= 1'b0;
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) bit_q <= 4'h0;
    // the clock fall that closes a start wraps this to zero
    else if (start_w) bit_q <= 4'hf;
    else if (fall_w) bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
  end
  // byte index saturates, data bytes all look alike
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) byte_q <= 2'h0;
    else if (start_w) byte_q <= 2'h0;
    else if (fall_w && bit_q == 4'h8 && byte_q != 2'h3) byte_q <= byte_q + 2'h1;
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) sh_q <= 8'h0;
    else if (rise_w && bit_q < 4'h8) sh_q <= {sh_q[6:0], sda};
  end
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) acked_q <= 1'b0;
    else if (start_w) acked_q <= 1'b0;
    else if (slot_w && byte_q == 2'h0) acked_q <= ~d_sda_oe_n;
  end

  // ==========================================
  // assertions
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_scl_never_driven: assert property (d_scl_oe_n)
    else $error("device pulled the clock line");
  chk_idle_sda_released: assert property (!busy_q |-> d_sda_oe_n)
    else $error("device pulls data line while bus idle");
  chk_idle_scl_high: assert property (!busy_q |-> scl)
    else $error("clock line low outside a frame");
  chk_stable_scl_high: assert property (scl && scl_q |-> $stable(d_sda_oe_n))
    else $error("device data pull changed while clock high");
  chk_pull_in_slot: assert property ($fell(d_sda_oe_n) |-> bit_q == 4'h8)
    else $error("device pulled data outside the ninth bit");
  chk_ack_release: assert property (
    fall_w && bit_q == 4'h8 && !d_sda_oe_n |-> ##[1:8] d_sda_oe_n)
    else $error("acknowledge not released after ninth clock");
  chk_addr_ack_match: assert property (
    slot_w && byte_q == 2'h0 |-> d_sda_oe_n == !match_w)
    else $error("address acknowledge does not follow the match");
  chk_data_byte_ack: assert property (
    slot_w && byte_q != 2'h0 && acked_q |-> !d_sda_oe_n)
    else $error("data byte not acknowledged");

  cover property (slot_w && byte_q == 2'h0 && sh_q[7:3] == 5'h01);
  cover property (slot_w && sh_q == 8'h90 && !d_sda_oe_n);
  cover property (slot_w && byte_q == 2'h3 && !d_sda_oe_n);
endmodule // dac_link_monitor

// File: tb/tb_quad_dac_two_wire_slave.sv
`timescale 1ns/10ps
// ==========================================
// bench: master and slave facing each other
module tb_quad_dac_two_wire_slave;
  logic             clk_i, reset_i, user_clk, start, hs;
  logic [6:0]       addr;
  logic [7:0]       ctrl;
  logic [15:0]      data;
  logic             busy, done, nack, hs_act, upd, hs_flag;
  logic [3:0][15:0] code;
  logic [15:0]      exp_code [4];
  logic [6:0]       tbl [7];
  logic [31:0]      r1, r2;
  logic [1:0]       sel_pins;
  int               n_fail, checks, n_upd, seed;

  two_wire_if bus_if ();
  dac_link_slave u_dac_link_slave (.clk_i(clk_i), .reset_i(reset_i),
    .user_clk_i(user_clk), .select_pin_upper_i(sel_pins[1]),
    .select_pin_lower_i(sel_pins[0]), .code_o(code), .update_o(upd),
    .high_speed_operation_o(hs_flag), .bus(bus_if.device));
  dac_link_master u_dac_link_master (.clk_i(clk_i), .reset_i(reset_i),
    .start_i(start), .hs_i(hs), .addr_i(addr), .ctrl_i(ctrl),
    .data_i(data), .busy_o(busy), .done_o(done), .nack_o(nack),
    .hs_active_o(hs_act), .bus(bus_if.master));
  dac_link_monitor #(.SEL(2'h2)) u_dac_link_monitor (.clk_i(clk_i),
    .reset_i(reset_i), .scl(bus_if.scl), .sda(bus_if.sda),
    .d_scl_oe_n(bus_if.d_scl_oe_n), .d_sda_oe_n(bus_if.d_sda_oe_n));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // unrelated phase to the sampling clock
  initial begin
    user_clk = 1'b0;
    #7;
    forever #62.5 user_clk = ~user_clk;
  end
  always @(posedge user_clk) if (upd === 1'b1) n_upd++;

  // ==========================================
  // helpers
  task check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  function logic exp_ack(input logic [6:0] a);
    return (a == {5'h13, 2'h2}) || (a == 7'h48);
  endfunction

  // a write to 00001xx looks like a master code and switches speed too
  function logic exp_hs(input logic h, input logic [6:0] a);
    return h || (a[6:2] == 5'h01);
  endfunction

  task xfer(input logic h, input logic [6:0] a, input logic [7:0] c,
            input logic [15:0] d);
    int   k, u0;
    logic ack, seen_hs;
    ack = exp_ack(a);
    u0 = n_upd;
    seen_hs = 1'b0;
    k = 0;
    @(posedge clk_i);
    start <= 1'b1;
    hs <= h;
    addr <= a;
    ctrl <= c;
    data <= d;
    @(posedge clk_i);
    start <= 1'b0;
    while (done !== 1'b1 && k < 20000) begin
      @(posedge clk_i) #1;
      k++;
      if (hs_flag === 1'b1) seen_hs = 1'b1;
    end
    if (k == 20000) begin
      n_fail++;
      tally_and_finish;
    end
    check("nack", {15'h0, ~ack}, {15'h0, nack});
    check("hs seen", {15'h0, exp_hs(h, a)}, {15'h0, seen_hs});
    if (ack) exp_code[c[2:1]] = d;
    // crossing lands within 3..4 user clocks
    repeat (6) @(posedge user_clk);
    #1;
    check("hs after stop", 16'h0, {15'h0, hs_flag});
    check("updates", {15'h0, ack}, 16'(n_upd - u0));
    for (int ch = 0; ch < 4; ch++) check("code", exp_code[ch], code[ch]);
    $display("test addr %h hs %b done", a, h);
  endtask

  // ==========================================
  // main sequence
  initial begin
    seed = 21348;
    n_fail = 0;
    checks = 0;
    n_upd = 0;
    start = 1'b0;
    hs = 1'b0;
    addr = 7'h0;
    ctrl = 8'h0;
    data = 16'h0;
    reset_i = 1'b1;
    sel_pins = 2'h2;
    for (int ch = 0; ch < 4; ch++) exp_code[ch] = 16'h0;
    // general call, 10-bit prefix, other straps, broadcast, own
    tbl = '{7'h00, 7'h78, 7'h4c, 7'h4d, 7'h4f, 7'h48, 7'h4e};
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < 7; i++) begin
      xfer(i[0], tbl[i], {5'h0, i[1:0], 1'b0}, i[0] ? 16'hffff : 16'h0001);
    end
    // straps move after power-up: the address must stay where it was
    @(posedge clk_i);
    sel_pins <= 2'h1;
    xfer(1'b0, 7'h4e, 8'h06, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      r1 = $random(seed);
      r2 = $random(seed);
      xfer(r2[31], r2[30] ? 7'h4e : r2[6:0], r1[7:0], r1[23:8]);
    end
    tally_and_finish;
  end
endmodule // tb_quad_dac_two_wire_slave
